// file: fspc_ctrl.sv
// flash self-programming controller with avalon-mm register slave
// What this block does
// - data pair holds one 14-bit program word for reads and writes
// - address pair forms a 15-bit word address, high byte and low byte
// - an internal timer times every erase and row program
// - code guard at 0 blocks external programmer access, not self-write
// - self-write guard field refuses erase and program in guarded region
// - read and write strobes settable only; hardware clears them when done
// - writes proceed only with write permit set; permit clear at power-up
// - warm reset during the stall of an erase or row program sets the write abort flag
// - unlock key register is write-only and reads as zero
// - rows of 32 words of 14 bits with 32 write latches
// - latches only loaded through unlocked writes of the data pair
// - array read on second cycle after read strobe, data next cycle
// - data pair keeps read value until next read or software write
// - erase, latch load and programs need the full unlock sequence
// - erase or row program forces two no-ops then stalls about 2 ms
// - latch load forces two no-ops and continues without stall
// - latch-only select loads a latch; clear programs the latch row
// - erase select with write permit erases the addressed row
// - low five address bits pick the latch, upper ten the row
// - all latches return to 3FFFh after every completed row program or erase
`timescale 1ns/1ps
`default_nettype none

module fspc_ctrl
	import fspc_pkg::*;
#(
	parameter int WRITE_CYCLES = FSPC_WRITE_CYCLES,
	parameter int MEM_WORDS    = FSPC_MEM_WORDS
) (
	// clock and resets
	input  wire logic                   core_clk_in,
	input  wire logic                   reset_n_in,
	input  wire logic                   warm_reset_in,
	// avalon-mm slave
	input  wire logic [4:0]             avs_address_in,
	input  wire logic                   avs_read_in,
	input  wire logic                   avs_write_in,
	input  wire logic [3:0]             avs_byteenable_in,
	input  wire logic [31:0]            avs_writedata_in,
	output logic      [31:0]            avs_readdata_out,
	output logic                        avs_waitrequest_out,
	// configuration word bits
	input  wire logic                   code_guard_in,
	input  wire logic [1:0]             self_write_guard_in,
	output logic                        ext_prog_access_ok_out,
	// processor sequencing
	output logic                        cpu_force_nop_out,
	output logic                        cpu_stall_out,
	// program memory array port
	output logic [FSPC_ADDR_W-1:0]      nvm_addr_out,
	output logic                        nvm_rd_out,
	output logic                        nvm_cfg_space_out,
	input  wire logic [FSPC_WORD_W-1:0] nvm_rdata_in,
	output logic                        nvm_we_out,
	output logic [FSPC_WORD_W-1:0]      nvm_wdata_out,
	output logic                        nvm_erase_out
);

	// refuse parameters the sequencer cannot serve
	if (WRITE_CYCLES < FSPC_ROW_WORDS + 1 || WRITE_CYCLES > 1_000_000_000) begin : g_chk_time
		$error("WRITE_CYCLES out of range");
	end
	if (MEM_WORDS < 4 * FSPC_ROW_WORDS || MEM_WORDS > FSPC_MEM_WORDS) begin : g_chk_mem
		$error("MEM_WORDS out of range");
	end

	localparam int TMR_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WRITE_CYCLES - 1);
	localparam logic [FSPC_ADDR_W-1:0] QUARTER_END = FSPC_ADDR_W'(MEM_WORDS / 4);
	localparam logic [FSPC_ADDR_W-1:0] HALF_END    = FSPC_ADDR_W'(MEM_WORDS / 2);

	logic                   rst_sync1_reg;
	logic                   rst_sync2_reg;
	logic                   rst_n;
	logic                   cg_sync1_reg;
	logic                   cg_sync2_reg;
	logic [1:0]             wg_sync1_reg;
	logic [1:0]             wg_sync2_reg;
	logic                   acc_reg;
	logic [31:0]            rdata_reg;
	logic [31:0]            rdata_next;
	logic                   do_wr;
	logic                   ctl_wr;
	logic [7:0]             wbyte;
	logic [6:0]             addr_high_reg;
	logic [7:0]             addr_low_reg;
	logic [5:0]             data_high_reg;
	logic [7:0]             data_low_reg;
	logic [FSPC_ADDR_W-1:0] prog_addr;
	logic [FSPC_WORD_W-1:0] prog_data;
	logic                   rd_reg;
	logic                   wr_reg;
	logic                   write_permit_reg;
	logic                   write_abort_flag_reg;
	logic                   erase_reg;
	logic                   latch_only_select_reg;
	logic                   config_space_select_reg;
	logic [1:0]             key_stage_reg;
	logic                   unlocked;
	logic                   guarded;
	logic                   start_rd;
	logic                   start_wr;
	logic [1:0]             start_op;
	logic                   latch_load;
	logic                   latch_clear;
	logic                   abort_evt;
	fspc_state_e            state_reg;
	logic [1:0]             op_reg;
	logic [TMR_W-1:0]       tmr_reg;
	logic [FSPC_IDX_W-1:0]  idx_reg;
	logic                   idx_run_reg;
	logic [FSPC_WORD_W-1:0] latch_mem [FSPC_ROW_WORDS];
	logic [FSPC_ADDR_W-1:0] nvm_addr_reg;
	logic [FSPC_WORD_W-1:0] nvm_wdata_reg;
	logic                   nvm_rd_reg;
	logic                   nvm_we_reg;
	logic                   nvm_erase_reg;

	// reset release through two flops
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	// configuration bits come from outside, synchronise them
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cg_sync1_reg <= 1'b1;
			cg_sync2_reg <= 1'b1;
			wg_sync1_reg <= FSPC_GUARD_NONE;
			wg_sync2_reg <= FSPC_GUARD_NONE;
		end else begin
			cg_sync1_reg <= code_guard_in;
			cg_sync2_reg <= cg_sync1_reg;
			wg_sync1_reg <= self_write_guard_in;
			wg_sync2_reg <= wg_sync1_reg;
		end
	end
	assign ext_prog_access_ok_out = cg_sync2_reg;

	assign prog_addr = {addr_high_reg, addr_low_reg};
	assign prog_data = {data_high_reg, data_low_reg};

	// guarded region check on the loaded address
	always_comb begin
		case (wg_sync2_reg)
			FSPC_GUARD_NONE:    guarded = 1'b0;
			FSPC_GUARD_QUARTER: guarded = prog_addr < QUARTER_END;
			FSPC_GUARD_HALF:    guarded = prog_addr < HALF_END;
			default:            guarded = 1'b1;
		endcase
	end

	// bus answers one cycle after the request; any operation stalls the bus
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= 1'b0;
		end else begin
			acc_reg <= (avs_read_in | avs_write_in) & ~acc_reg & (state_reg == FSPC_IDLE);
		end
	end
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~acc_reg;
	assign do_wr  = avs_write_in & acc_reg & avs_byteenable_in[0];
	assign ctl_wr = do_wr & (avs_address_in == FSPC_CONTROL_OFS);
	assign wbyte  = avs_writedata_in[7:0];

	// read mux, sampled one cycle ahead of the answer
	always_comb begin
		rdata_next = 32'h0;
		case (avs_address_in)
			FSPC_ADDR_LOW_OFS:  rdata_next[7:0] = addr_low_reg;
			FSPC_ADDR_HIGH_OFS: rdata_next[6:0] = addr_high_reg;
			FSPC_DATA_LOW_OFS:  rdata_next[7:0] = data_low_reg;
			FSPC_DATA_HIGH_OFS: rdata_next[5:0] = data_high_reg;
			FSPC_CONTROL_OFS: begin
				rdata_next[FSPC_CTL_RD]    = rd_reg;
				rdata_next[FSPC_CTL_WR]    = wr_reg;
				rdata_next[FSPC_CTL_WRITE_PERMIT]  = write_permit_reg;
				rdata_next[FSPC_CTL_WRITE_ABORT_FLAG] = write_abort_flag_reg;
				rdata_next[FSPC_CTL_ERASE] = erase_reg;
				rdata_next[FSPC_CTL_LATCH_ONLY_SELECT]  = latch_only_select_reg;
				rdata_next[FSPC_CTL_CONFIG_SPACE_SELECT]  = config_space_select_reg;
			end
			FSPC_KEY_OFS:       rdata_next = 32'h0;
			default:            rdata_next = 32'h0;
		endcase
	end
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0;
		end else if (!acc_reg) begin
			rdata_reg <= rdata_next;
		end
	end
	assign avs_readdata_out = rdata_reg;

	// address pair, software only
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			addr_low_reg  <= 8'h0;
			addr_high_reg <= 7'h0;
		end else if (do_wr) begin
			if (avs_address_in == FSPC_ADDR_LOW_OFS) begin
				addr_low_reg <= wbyte;
			end
			if (avs_address_in == FSPC_ADDR_HIGH_OFS) begin
				addr_high_reg <= wbyte[6:0];
			end
		end
	end

	// data pair: array capture or software write only
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			data_low_reg  <= 8'h0;
			data_high_reg <= 6'h0;
		end else if (state_reg == FSPC_RDCAP) begin
			data_low_reg  <= nvm_rdata_in[7:0];
			data_high_reg <= nvm_rdata_in[13:8];
		end else if (do_wr) begin
			if (avs_address_in == FSPC_DATA_LOW_OFS) begin
				data_low_reg <= wbyte;
			end
			if (avs_address_in == FSPC_DATA_HIGH_OFS) begin
				data_high_reg <= wbyte[5:0];
			end
		end
	end

	// key stage; any other accepted access breaks the sequence
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			key_stage_reg <= 2'h0;
		end else if (warm_reset_in) begin
			key_stage_reg <= 2'h0;
		end else if (acc_reg) begin
			if (do_wr && avs_address_in == FSPC_KEY_OFS && wbyte == FSPC_KEY_FIRST) begin
				key_stage_reg <= 2'h1;
			end else if (do_wr && avs_address_in == FSPC_KEY_OFS
					&& wbyte == FSPC_KEY_SECOND && key_stage_reg == 2'h1) begin
				key_stage_reg <= 2'h2;
			end else begin
				key_stage_reg <= 2'h0;
			end
		end
	end
	assign unlocked = key_stage_reg == 2'h2;

	// operation decode from the control byte being written
	always_comb begin
		if (wbyte[FSPC_CTL_ERASE]) begin
			start_op = FSPC_OP_ERASE;
		end else if (wbyte[FSPC_CTL_LATCH_ONLY_SELECT]) begin
			start_op = FSPC_OP_LATCH;
		end else begin
			start_op = FSPC_OP_PROG;
		end
	end
	// strobe without keys or permit is dropped
	assign start_wr = ctl_wr & wbyte[FSPC_CTL_WR] & wbyte[FSPC_CTL_WRITE_PERMIT] & unlocked
		& ~wbyte[FSPC_CTL_CONFIG_SPACE_SELECT] & ~(guarded & (start_op != FSPC_OP_LATCH));
	assign start_rd = ctl_wr & wbyte[FSPC_CTL_RD] & ~wbyte[FSPC_CTL_WR];
	assign abort_evt = warm_reset_in & (state_reg == FSPC_BUSY);

	// control bits; warm reset drops everything but the abort flag
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			write_permit_reg  <= 1'b0;
			erase_reg <= 1'b0;
			latch_only_select_reg  <= 1'b0;
			config_space_select_reg  <= 1'b0;
		end else if (warm_reset_in) begin
			write_permit_reg  <= 1'b0;
			erase_reg <= 1'b0;
			latch_only_select_reg  <= 1'b0;
			config_space_select_reg  <= 1'b0;
		end else if (ctl_wr) begin
			write_permit_reg  <= wbyte[FSPC_CTL_WRITE_PERMIT];
			erase_reg <= wbyte[FSPC_CTL_ERASE];
			latch_only_select_reg  <= wbyte[FSPC_CTL_LATCH_ONLY_SELECT];
			config_space_select_reg  <= wbyte[FSPC_CTL_CONFIG_SPACE_SELECT];
		end
	end

	// strobes set by software, cleared only by hardware
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else if (warm_reset_in) begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else begin
			if (start_rd) begin
				rd_reg <= 1'b1;
			end else if (state_reg == FSPC_RDCAP) begin
				rd_reg <= 1'b0;
			end
			if (start_wr) begin
				wr_reg <= 1'b1;
			end else if (latch_clear || (state_reg == FSPC_NOP2 && op_reg == FSPC_OP_LATCH)) begin
				wr_reg <= 1'b0;
			end
		end
	end

	// abort flag survives warm reset; set wins over software clear
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			write_abort_flag_reg <= 1'b0;
		end else if (abort_evt) begin
			write_abort_flag_reg <= 1'b1;
		end else if (ctl_wr) begin
			write_abort_flag_reg <= wbyte[FSPC_CTL_WRITE_ABORT_FLAG];
		end
	end

	// sequencer
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= FSPC_IDLE;
			op_reg    <= FSPC_OP_LATCH;
		end else if (warm_reset_in) begin
			state_reg <= FSPC_IDLE;
		end else begin
			case (state_reg)
				FSPC_IDLE: begin
					if (start_wr) begin
						state_reg <= FSPC_NOP1;
						op_reg    <= start_op;
					end else if (start_rd) begin
						state_reg <= FSPC_RD1;
					end
				end
				// second cycle after the strobe reads the array
				FSPC_RD1:   state_reg <= FSPC_RD2;
				FSPC_RD2:   state_reg <= FSPC_RDCAP;
				FSPC_RDCAP: state_reg <= FSPC_IDLE;
				FSPC_NOP1:  state_reg <= FSPC_NOP2;
				// latch load continues after the forced no-ops
				FSPC_NOP2: begin
					state_reg <= (op_reg == FSPC_OP_LATCH) ? FSPC_IDLE : FSPC_BUSY;
				end
				FSPC_BUSY: begin
					if (tmr_reg == '0) begin
						state_reg <= FSPC_IDLE;
					end
				end
				default:    state_reg <= FSPC_IDLE;
			endcase
		end
	end

	// forced no-ops, then stall for the write time
	assign cpu_force_nop_out = (state_reg == FSPC_RD1) | (state_reg == FSPC_RD2)
		| (state_reg == FSPC_NOP1) | (state_reg == FSPC_NOP2);
	assign cpu_stall_out = state_reg == FSPC_BUSY;

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tmr_reg <= '0;
		end else if (state_reg == FSPC_NOP2) begin
			tmr_reg <= TMR_LOAD;
		end else if (state_reg == FSPC_BUSY && tmr_reg != '0) begin
			tmr_reg <= tmr_reg - 1'b1;
		end
	end

	// row program walks the latches during the first cycles of the timer
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			idx_reg     <= '0;
			idx_run_reg <= 1'b0;
		end else if (state_reg == FSPC_NOP2) begin
			idx_reg     <= '0;
			idx_run_reg <= op_reg == FSPC_OP_PROG;
		end else if (state_reg != FSPC_BUSY || warm_reset_in) begin
			idx_run_reg <= 1'b0;
		end else if (idx_run_reg) begin
			idx_reg     <= idx_reg + 1'b1;
			idx_run_reg <= idx_reg != FSPC_IDX_W'(FSPC_ROW_WORDS - 1);
		end
	end

	// both latch load and row program store the current word
	assign latch_load  = start_wr & (start_op != FSPC_OP_ERASE);
	// blank latches once the timed operation ends
	assign latch_clear = (state_reg == FSPC_BUSY) & (tmr_reg == '0) & ~warm_reset_in;

	// one generate block per write latch
	// latches reachable only through unlocked data writes
	for (genvar g = 0; g < FSPC_ROW_WORDS; g++) begin : g_latch
		always_ff @(posedge core_clk_in or negedge rst_n) begin
			if (!rst_n) begin
				latch_mem[g] <= FSPC_BLANK_WORD;
			end else if (latch_clear) begin
				latch_mem[g] <= FSPC_BLANK_WORD;
			// low address bits pick the latch
			end else if (latch_load && prog_addr[FSPC_IDX_W-1:0] == FSPC_IDX_W'(g)) begin
				latch_mem[g] <= prog_data;
			end
		end
	end

	// array port, registered
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			nvm_addr_reg  <= '0;
			nvm_wdata_reg <= '0;
			nvm_rd_reg    <= 1'b0;
			nvm_we_reg    <= 1'b0;
			nvm_erase_reg <= 1'b0;
		end else begin
			nvm_rd_reg    <= (state_reg == FSPC_RD1) & ~warm_reset_in;
			// erase the row holding the loaded address
			nvm_erase_reg <= (state_reg == FSPC_NOP2) & (op_reg == FSPC_OP_ERASE)
				& ~warm_reset_in;
			nvm_we_reg    <= (state_reg == FSPC_BUSY) & idx_run_reg & ~warm_reset_in;
			if (state_reg == FSPC_RD1) begin
				nvm_addr_reg <= prog_addr;
			// row from upper bits, never crossing the row
			end else if (state_reg == FSPC_NOP2) begin
				nvm_addr_reg <= {prog_addr[FSPC_ADDR_W-1:FSPC_IDX_W], {FSPC_IDX_W{1'b0}}};
			end else if (state_reg == FSPC_BUSY) begin
				nvm_addr_reg  <= {prog_addr[FSPC_ADDR_W-1:FSPC_IDX_W], idx_reg};
				nvm_wdata_reg <= latch_mem[idx_reg];
			end
		end
	end
	assign nvm_addr_out      = nvm_addr_reg;
	assign nvm_wdata_out     = nvm_wdata_reg;
	assign nvm_rd_out        = nvm_rd_reg;
	assign nvm_we_out        = nvm_we_reg;
	assign nvm_erase_out     = nvm_erase_reg;
	assign nvm_cfg_space_out = config_space_select_reg;

endmodule

`default_nettype wire

// file: fspc_ctrl_chk.sv
// assertion checker for the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_chk
	import fspc_pkg::*;
#(
	parameter int WRITE_CYCLES = FSPC_WRITE_CYCLES
) (
	// clock and resets
	input wire logic                   core_clk_in,
	input wire logic                   reset_n_in,
	input wire logic                   warm_reset_in,
	// register bus and configuration
	input wire logic [4:0]             avs_address_in,
	input wire logic                   avs_read_in,
	input wire logic [31:0]            avs_readdata_out,
	input wire logic                   avs_waitrequest_out,
	input wire logic                   code_guard_in,
	input wire logic                   ext_prog_access_ok_out,
	// sequencing and array port
	input wire logic                   cpu_force_nop_out,
	input wire logic                   cpu_stall_out,
	input wire logic [FSPC_ADDR_W-1:0] nvm_addr_out,
	input wire logic                   nvm_rd_out,
	input wire logic                   nvm_we_out,
	input wire logic                   nvm_erase_out
);
	// run lengths counted, since a 2 ms stall cannot be a repetition
	int stall_cnt;
	int we_cnt;
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stall_cnt <= 0;
			we_cnt    <= 0;
		end else begin
			stall_cnt <= cpu_stall_out ? stall_cnt + 1 : 0;
			we_cnt    <= nvm_we_out ? we_cnt + 1 : 0;
		end
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);

	a_read_slot: assert property (nvm_rd_out |-> cpu_force_nop_out && $past(cpu_force_nop_out) ##1 !nvm_rd_out)
		else $error("array read outside second forced cycle");
	a_nop_pair: assert property ($rose(cpu_force_nop_out) |=> cpu_force_nop_out ##1 !cpu_force_nop_out)
		else $error("forced no-op run not two cycles");
	a_stall_len: assert property ($fell(cpu_stall_out) && !$past(warm_reset_in) |-> stall_cnt == WRITE_CYCLES)
		else $error("stall length wrong");
	a_stall_entry: assert property ($rose(cpu_stall_out) |-> $past(cpu_force_nop_out) && $past(cpu_force_nop_out, 2))
		else $error("stall not preceded by two no-ops");
	a_we_burst: assert property ($fell(nvm_we_out) |-> we_cnt == FSPC_ROW_WORDS)
		else $error("row program not 32 words");
	a_we_start: assert property ($rose(nvm_we_out) |-> nvm_addr_out[4:0] == 5'h00 && cpu_stall_out)
		else $error("row program not from row base");
	a_we_step: assert property (nvm_we_out && $past(nvm_we_out) |-> nvm_addr_out == $past(nvm_addr_out) + 15'h0001)
		else $error("row program address step wrong");
	a_erase_row: assert property (nvm_erase_out |-> nvm_addr_out[4:0] == 5'h00 && cpu_stall_out ##1 !nvm_erase_out)
		else $error("erase pulse not at row base");
	a_key_zero: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == FSPC_KEY_OFS |-> avs_readdata_out == 32'h0)
		else $error("key register read not zero");
	a_guard_follow: assert property ($stable(code_guard_in) [*5] |-> ext_prog_access_ok_out == code_guard_in)
		else $error("external access flag does not follow code guard");

	// main scenarios reached
	c_read: cover property (nvm_rd_out);
	c_erase: cover property (nvm_erase_out);
	c_prog: cover property ($fell(nvm_we_out));
endmodule

bind fspc_ctrl fspc_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_fspc_ctrl_chk (
	.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .warm_reset_in(warm_reset_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.code_guard_in(code_guard_in), .ext_prog_access_ok_out(ext_prog_access_ok_out),
	.cpu_force_nop_out(cpu_force_nop_out), .cpu_stall_out(cpu_stall_out),
	.nvm_addr_out(nvm_addr_out), .nvm_rd_out(nvm_rd_out), .nvm_we_out(nvm_we_out),
	.nvm_erase_out(nvm_erase_out)
);
`default_nettype wire

// file: fspc_nvm_model.sv
// program memory array model behind the controller's array port
`timescale 1ns/1ps
`default_nettype none
module fspc_nvm_model
	import fspc_pkg::*;
#(
	parameter int WORDS = 1024
) (
	// clock
	input wire logic                   core_clk_in,
	// array port
	input wire logic [FSPC_ADDR_W-1:0] nvm_addr_in,
	input wire logic                   nvm_rd_in,
	input wire logic                   nvm_we_in,
	input wire logic                   nvm_erase_in,
	input wire logic [FSPC_WORD_W-1:0] nvm_wdata_in,
	output logic     [FSPC_WORD_W-1:0] nvm_rdata_out
);
	logic [FSPC_WORD_W-1:0] mem [WORDS];

	// recognisable preload so untouched words differ from blank
	initial begin
		for (int i = 0; i < WORDS; i++) mem[i] = 14'(i * 5 + 3);
	end

	// row erase and word program; only ten address bits are modelled
	always @(posedge core_clk_in) begin
		if (nvm_erase_in)
			for (int i = 0; i < FSPC_ROW_WORDS; i++) mem[{nvm_addr_in[9:5], 5'(i)}] <= FSPC_BLANK_WORD;
		if (nvm_we_in)
			mem[nvm_addr_in[9:0]] <= nvm_wdata_in;
		// valid only the cycle after a read pulse, scrambled otherwise
		nvm_rdata_out <= nvm_rd_in ? mem[nvm_addr_in[9:0]] : ~nvm_rdata_out;
	end
endmodule
`default_nettype wire

// file: fspc_pkg.sv
// constants shared by the flash self-programming controller
package fspc_pkg;

	// register byte offsets on the avalon slave
	localparam logic [4:0] FSPC_ADDR_LOW_OFS  = 5'h00;
	localparam logic [4:0] FSPC_ADDR_HIGH_OFS = 5'h04;
	localparam logic [4:0] FSPC_DATA_LOW_OFS  = 5'h08;
	localparam logic [4:0] FSPC_DATA_HIGH_OFS = 5'h0c;
	localparam logic [4:0] FSPC_CONTROL_OFS   = 5'h10;
	localparam logic [4:0] FSPC_KEY_OFS       = 5'h14;

	// control register bit positions
	localparam int FSPC_CTL_RD    = 0;
	localparam int FSPC_CTL_WR    = 1;
	localparam int FSPC_CTL_WRITE_PERMIT  = 2;
	localparam int FSPC_CTL_WRITE_ABORT_FLAG = 3;
	localparam int FSPC_CTL_ERASE = 4;
	localparam int FSPC_CTL_LATCH_ONLY_SELECT  = 5;
	localparam int FSPC_CTL_CONFIG_SPACE_SELECT  = 6;

	// unlock key bytes and blank latch value
	localparam logic [7:0]  FSPC_KEY_FIRST  = 8'h55;
	localparam logic [7:0]  FSPC_KEY_SECOND = 8'haa;
	localparam logic [13:0] FSPC_BLANK_WORD = 14'h3fff;

	// geometry
	localparam int FSPC_WORD_W    = 14;
	localparam int FSPC_ADDR_W    = 15;
	localparam int FSPC_ROW_WORDS = 32;
	localparam int FSPC_IDX_W     = 5;
	localparam int FSPC_MEM_WORDS = 32768;

	// write/erase timing at the core clock rate
	localparam int FSPC_CLK_HZ        = 25_000_000;
	localparam int FSPC_WRITE_TIME_US = 2000;
	localparam int FSPC_WRITE_CYCLES  = FSPC_WRITE_TIME_US * (FSPC_CLK_HZ / 1_000_000);

	// self-write guard codes
	localparam logic [1:0] FSPC_GUARD_ALL     = 2'h0;
	localparam logic [1:0] FSPC_GUARD_HALF    = 2'h1;
	localparam logic [1:0] FSPC_GUARD_QUARTER = 2'h2;
	localparam logic [1:0] FSPC_GUARD_NONE    = 2'h3;

	// operation kinds
	localparam logic [1:0] FSPC_OP_LATCH = 2'h0;
	localparam logic [1:0] FSPC_OP_ERASE = 2'h1;
	localparam logic [1:0] FSPC_OP_PROG  = 2'h2;

	typedef enum logic [6:0] {
		FSPC_IDLE  = 7'h01,
		FSPC_RD1   = 7'h02,
		FSPC_RD2   = 7'h04,
		FSPC_RDCAP = 7'h08,
		FSPC_NOP1  = 7'h10,
		FSPC_NOP2  = 7'h20,
		FSPC_BUSY  = 7'h40
	} fspc_state_e;

endpackage

// file: testbench.sv
// self-checking testbench for the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fspc_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, warm = 1'b0, rd = 1'b0, wr = 1'b0, cg = 1'b1;
	logic [4:0]  adr = '0;
	logic [31:0] wd = '0, rdat;
	logic [1:0]  swg = FSPC_GUARD_NONE;
	logic        wait_r, ext_ok, nop, stall, n_rd, n_we, n_er, n_cfg;
	logic [14:0] n_adr;
	logic [13:0] n_wd, n_rdat;
	logic [31:0] q;
	int          n_fail = 0, check_count = 0, cycles = 0;

	// clock at 25 MHz
	always #20 clk = ~clk;

	fspc_ctrl #(.WRITE_CYCLES(40), .MEM_WORDS(1024)) u_fspc_ctrl (
		.core_clk_in(clk), .reset_n_in(rst_n), .warm_reset_in(warm),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(4'hf),
		.avs_writedata_in(wd), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_r),
		.code_guard_in(cg), .self_write_guard_in(swg), .ext_prog_access_ok_out(ext_ok),
		.cpu_force_nop_out(nop), .cpu_stall_out(stall), .nvm_addr_out(n_adr), .nvm_rd_out(n_rd),
		.nvm_cfg_space_out(n_cfg), .nvm_rdata_in(n_rdat), .nvm_we_out(n_we),
		.nvm_wdata_out(n_wd), .nvm_erase_out(n_er));

	fspc_nvm_model u_fspc_nvm_model (
		.core_clk_in(clk), .nvm_addr_in(n_adr), .nvm_rd_in(n_rd), .nvm_we_in(n_we),
		.nvm_erase_in(n_er), .nvm_wdata_in(n_wd), .nvm_rdata_out(n_rdat));

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// hang guard, far above the expected several hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [13:0] pat(input int a);
		return 14'(a * 5 + 3);
	endfunction

	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		rd  <= !w;
		wr  <= w;
		wd  <= {24'h0, d};
		do @(posedge clk); while (wait_r !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic set_word(input logic [4:0] lo, input logic [15:0] v);
		bus(lo, 1'b1, v[7:0]);
		bus(lo + 5'h04, 1'b1, v[15:8]);
	endtask

	task automatic unlock(input logic [7:0] ctl);
		bus(FSPC_KEY_OFS, 1'b1, FSPC_KEY_FIRST);
		bus(FSPC_KEY_OFS, 1'b1, FSPC_KEY_SECOND);
		bus(FSPC_CONTROL_OFS, 1'b1, ctl);
	endtask

	// control read waits out the operation
	task automatic chk_mem(input int a, input logic [13:0] e);
		bus(FSPC_CONTROL_OFS, 1'b0, 8'h00);
		check(32'(u_fspc_nvm_model.mem[a]), 32'(e));
	endtask

	task automatic t_reset;
		bus(FSPC_CONTROL_OFS, 1'b0, 8'h00);
		check(q, 32'h0);
		bus(FSPC_KEY_OFS, 1'b0, 8'h00);
		check(q, 32'h0);
		bus(5'h18, 1'b0, 8'h00);
		check(q, 32'h0);
		check(32'(ext_ok), 32'h1);
	endtask

	task automatic t_read;
		// bus stall covers the two no-ops
		set_word(FSPC_ADDR_LOW_OFS, 16'h0323);
		bus(FSPC_CONTROL_OFS, 1'b1, 8'h01);
		bus(FSPC_DATA_LOW_OFS, 1'b0, 8'h00);
		check(q, 32'(pat(16'h0323) & 14'h00ff));
		bus(FSPC_DATA_HIGH_OFS, 1'b0, 8'h00);
		check(q, 32'(pat(16'h0323) >> 8));
		bus(FSPC_CONTROL_OFS, 1'b0, 8'h00);
		check(q & 32'h1, 32'h0);
		bus(FSPC_DATA_LOW_OFS, 1'b1, 8'h5a);
		bus(FSPC_DATA_LOW_OFS, 1'b0, 8'h00);
		check(q, 32'h5a);
	endtask

	task automatic t_program;
		set_word(FSPC_ADDR_LOW_OFS, 16'h03c0);
		set_word(FSPC_DATA_LOW_OFS, 16'h1234);
		unlock(8'h26);
		chk_mem(16'h03c0, pat(16'h03c0));
		set_word(FSPC_ADDR_LOW_OFS, 16'h03c5);
		set_word(FSPC_DATA_LOW_OFS, 16'h0abc);
		unlock(8'h26);
		set_word(FSPC_ADDR_LOW_OFS, 16'h03df);
		set_word(FSPC_DATA_LOW_OFS, 16'h2def);
		unlock(8'h06);
		chk_mem(16'h03c0, 14'h1234);
		chk_mem(16'h03c5, 14'h0abc);
		chk_mem(16'h03df, 14'h2def);
		chk_mem(16'h03c1, FSPC_BLANK_WORD);
		bus(FSPC_CONTROL_OFS, 1'b0, 8'h00);
		check(q & 32'h2, 32'h0);
		set_word(FSPC_ADDR_LOW_OFS, 16'h03e1);
		set_word(FSPC_DATA_LOW_OFS, 16'h0111);
		unlock(8'h06);
		chk_mem(16'h03e1, 14'h0111);
		chk_mem(16'h03ff, FSPC_BLANK_WORD);
		set_word(FSPC_ADDR_LOW_OFS, 16'h03c7);
		unlock(8'h16);
		chk_mem(16'h03c0, FSPC_BLANK_WORD);
		chk_mem(16'h03df, FSPC_BLANK_WORD);
		chk_mem(16'h03a0, pat(16'h03a0));
	endtask

	task automatic t_refuse;
		set_word(FSPC_ADDR_LOW_OFS, 16'h0200);
		set_word(FSPC_DATA_LOW_OFS, 16'h0001);
		bus(FSPC_CONTROL_OFS, 1'b1, 8'h06);
		bus(FSPC_KEY_OFS, 1'b1, FSPC_KEY_FIRST);
		bus(FSPC_DATA_LOW_OFS, 1'b0, 8'h00);
		bus(FSPC_KEY_OFS, 1'b1, FSPC_KEY_SECOND);
		bus(FSPC_CONTROL_OFS, 1'b1, 8'h06);
		unlock(8'h46);
		chk_mem(16'h0200, pat(16'h0200));
		check(32'(n_cfg), 32'h1);
		unlock(8'h02);
		chk_mem(16'h0200, pat(16'h0200));
		bus(FSPC_CONTROL_OFS, 1'b0, 8'h00);
		check(q & 32'h2, 32'h0);
	endtask

	// every guard code against an erase of a row in the second quarter
	task automatic t_guard;
		for (int k = 0; k < 4; k++) begin
			swg <= 2'(k);
			repeat (4) @(posedge clk);
			set_word(FSPC_ADDR_LOW_OFS, 16'(16'h0100 + k * 32));
			unlock(8'h16);
			chk_mem(16'h0100 + k * 32, k < 2 ? pat(16'h0100 + k * 32) : FSPC_BLANK_WORD);
		end
	endtask

	task automatic t_abort;
		set_word(FSPC_ADDR_LOW_OFS, 16'h0240);
		unlock(8'h16);
		do @(posedge clk); while (stall !== 1'b1);
		warm <= 1'b1;
		@(posedge clk);
		warm <= 1'b0;
		bus(FSPC_CONTROL_OFS, 1'b0, 8'h00);
		check(q & 32'h8, 32'h8);
		cg <= 1'b0;
		repeat (6) @(posedge clk);
		check(32'(ext_ok), 32'h0);
		cg <= 1'b1;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_read();
		t_program();
		t_refuse();
		t_guard();
		t_abort();
		repeat (8) @(posedge clk);
		print_verdict();
	end
endmodule
`default_nettype wire
